// File: hw/cfeh_pkg.sv
// Purpose: Shared constants for the charger event link, both ends
// Assumes: 10 MHz core clock on both ends
// Notes: Event index order follows the event register map
package cfeh_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam logic [6:0] SLAVE_ADDR = 7'h53;
  localparam logic [7:0] REG_TOP = 8'h01;
  localparam logic [7:0] REG_FUNC = 8'h02;
  localparam logic [7:0] REG_VBUS = 8'h04;
  localparam logic [7:0] REG_STAT0 = 8'h10;
  localparam logic [7:0] REG_FLAG0 = 8'h20;
  localparam logic [7:0] REG_FLAG3 = 8'h23;
  localparam logic [7:0] REG_MASK0 = 8'h30;
  localparam int TOP_TO_DIS_BIT = 3;
  localparam int FUNC_BOOST_BIT = 1;
  localparam int FUNC_CHG_BIT = 0;
  localparam int VBUS_OVP_LSB = 6;
  localparam logic [7:0] TOP_RST = 8'h00;
  localparam logic [7:0] FUNC_RST = 8'h01;
  localparam logic [7:0] VBUS_RST = 8'h40;
  localparam int NUM_EV = 27;
  localparam logic [26:0] MASK_RST = 27'h7ffffff;
  localparam logic [26:0] NO_LIVE_STAT = 27'h6100060;
  localparam int EV_THERMAL_REGULATION_THRESHOLD = 10;
  localparam int EV_SYSOV = 13;
  localparam int EV_BATOV = 14;
  localparam int EV_SHORT = 20;
  localparam int EV_OTP = 21;
  localparam int EV_VACOV = 22;
  localparam int EV_BFAULT = 26;
  localparam int NUM_DET = 11;
  localparam int D_VACOV = 0;
  localparam int D_SYSOV = 1;
  localparam int D_SHORT = 2;
  localparam int D_BATOV = 3;
  localparam int D_DEPL = 4;
  localparam int D_THERMAL_REGULATION_THRESHOLD = 5;
  localparam int D_OTP = 6;
  localparam int D_OTP_OK = 7;
  localparam int D_BSHORT = 8;
  localparam int D_VBUS_IN = 9;
  localparam int D_SHIP_EXIT = 10;
  localparam logic [1:0] OVP_BOOST_SEL = 2'h1;
  localparam logic [3:0] CHG_FAULT = 4'h8;
  localparam logic [2:0] HICCUP_LAST = 3'h6;
  localparam int ALERT_US = 256;
  localparam logic [11:0] ALERT_CYC = 12'((ALERT_US * (CLK_HZ / 1_000_000)));
  localparam logic [11:0] ALERT_GAP = 12'h004;
  localparam int TIMEOUT_MS = 1000;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SCL_QUARTER = 25;
  typedef enum logic [3:0] {
    CFEH_IDLE = 4'h0,
    CFEH_ADDR = 4'h1,
    CFEH_AACK = 4'h2,
    CFEH_REG = 4'h3,
    CFEH_RACK = 4'h4,
    CFEH_WR = 4'h5,
    CFEH_WACK = 4'h6,
    CFEH_RD = 4'h7
  } cfeh_bus_e;
  typedef enum logic [2:0] {
    CFEH_H_IDLE = 3'h0,
    CFEH_H_START = 3'h1,
    CFEH_H_BIT = 3'h2,
    CFEH_H_RSTART = 3'h3,
    CFEH_H_STOP = 3'h4
  } cfeh_host_e;
endpackage : cfeh_pkg

// File: hw/cfeh_link_if.sv
// Purpose: Two-wire bus and alert line between host and charger
// Assumes: Pull-ups on all three wires
// Notes: Wire levels resolved here from the enables
interface cfeh_link_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic int_d_o;
  logic int_d_oe;
  logic scl;
  logic sda;
  logic int_n;
  assign scl = scl_h_oe ? scl_h_o : 1'b1;
  assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
  assign int_n = int_d_oe ? int_d_o : 1'b1;
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe, output int_d_o, output int_d_oe);
  modport host (input scl, input sda, input int_n, output scl_h_o, output scl_h_oe, output sda_h_o,
                output sda_h_oe);
endinterface : cfeh_link_if

// File: hw/cfeh_device.sv
// Purpose: Charger event latching, fault reactions and serial slave
// Assumes: Detector levels arrive asynchronously; ev_i and stat_i on clk
// Notes: Registers reached only over the two-wire slave
// Operation
// - Alert pin is open-drain, pulls low only
// - Unmasked events give 256us low pulses; events during a pulse give one more pulse after the gap
// - All event masks set after reset
// - Event flags latched at 0x20-0x23 until read
// - Host read clears flags; new events still pulse
// - 27 flags and masks; live status mostly
// - Buck input overvolt stops switching, fault code
// - Boost forces 6.35V threshold if offset 0x04 bit 7 set, overvolt ends boost
// - Host re-enables boost only below hysteresis
// - Boost short: six hiccups then boost fault on the seventh
// - System overvolt stops buck, enables sink
// - System short latches battery switch off
// - Battery overvolt disables charging, raises alert
// - Over-discharge opens switch until input returns
// - Thermal regulation throttles charging, raises alert
// - Buck over-temperature shuts down until recovery
// - Boost over-temperature clears boost enable
// - Slave at address 53H, host masters
// - Write is start, address, register, data, stop
// - Data low over 1s resets slave
// - Offset 0x01 bit 3 disables timeout
// - Timeout disable defaults to 0
module cfeh_device #(
  parameter int TIMEOUT_CYC = cfeh_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  cfeh_link_if.dev link,
  input wire logic [cfeh_pkg::NUM_DET-1:0] det_i,
  input wire logic [cfeh_pkg::NUM_EV-1:0] ev_i,
  input wire logic [cfeh_pkg::NUM_EV-1:0] stat_i,
  input wire logic [3:0] charge_state_i,
  output logic switching_stop_o,
  output logic sys_sink_en_o,
  output logic battery_path_switch_o,
  output logic charge_enable_o,
  output logic thermal_reg_active_o,
  output logic boost_enable_o,
  output logic [1:0] input_overvolt_threshold_sel_o,
  output logic [3:0] charge_state_code_o,
  output logic input_overvolt_status_o
);
  typedef struct packed {
    logic [cfeh_pkg::NUM_DET-1:0] det_m;
    logic [cfeh_pkg::NUM_DET-1:0] det_s;
    logic [cfeh_pkg::NUM_DET-1:0] det_p;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    cfeh_pkg::cfeh_bus_e st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic od_lvl;
    logic [23:0] to_cnt;
    logic [7:0] top;
    logic [7:0] func;
    logic [7:0] vbus;
    logic [26:0] mask;
    logic [26:0] flags;
    logic int_oe;
    logic pend;
    logic [11:0] acnt;
    logic [2:0] hic;
    logic ship;
    logic depl;
    logic otp_off;
    logic sw_stop;
    logic sink;
    logic path;
    logic chg;
    logic thermal_regulation_threshold;
    logic [1:0] ovp_sel;
    logic [3:0] code;
    logic ov_stat;
  } cfeh_dev_s;

  cfeh_dev_s s_r;
  cfeh_dev_s s_nxt;
  logic [cfeh_pkg::NUM_DET-1:0] rise;
  logic [26:0] ev;
  logic [26:0] live;
  logic [26:0] clr;
  logic scl_rise;
  logic scl_fall;
  logic boost;

  function automatic logic [7:0] pick(input logic [26:0] v, input logic [1:0] k);
    logic [31:0] w;
    w = {5'h00, v};
    pick = w[k*8 +: 8];
  endfunction : pick

  function automatic logic [26:0] put(input logic [26:0] v, input logic [1:0] k, input logic [7:0] b);
    logic [31:0] w;
    w = {5'h00, v};
    w[k*8 +: 8] = b;
    put = w[26:0];
  endfunction : put

  function automatic logic [7:0] rd(input cfeh_dev_s v, input logic [26:0] l);
    if (v.ptr[7:2] == cfeh_pkg::REG_FLAG0[7:2]) begin
      rd = pick(v.flags, v.ptr[1:0]);
    end else if (v.ptr[7:2] == cfeh_pkg::REG_STAT0[7:2]) begin
      rd = pick(l, v.ptr[1:0]);
    end else if (v.ptr[7:2] == cfeh_pkg::REG_MASK0[7:2]) begin
      rd = pick(v.mask, v.ptr[1:0]);
    end else begin
      case (v.ptr)
        cfeh_pkg::REG_TOP: rd = v.top;
        cfeh_pkg::REG_FUNC: rd = v.func;
        cfeh_pkg::REG_VBUS: rd = v.vbus;
        default: rd = 8'h00;
      endcase
    end
  endfunction : rd

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.det_m = det_i;
    s_nxt.det_s = s_r.det_m;
    s_nxt.det_p = s_r.det_s;
    s_nxt.scl_m = link.scl;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = link.sda;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    rise = s_r.det_s & ~s_r.det_p;
    scl_rise = s_r.scl_s & ~s_r.scl_p;
    scl_fall = ~s_r.scl_s & s_r.scl_p;
    clr = 27'h0000000;
    live = stat_i;
    live[cfeh_pkg::EV_VACOV] = s_r.det_s[cfeh_pkg::D_VACOV];
    live[cfeh_pkg::EV_SYSOV] = s_r.det_s[cfeh_pkg::D_SYSOV];
    live[cfeh_pkg::EV_BATOV] = s_r.det_s[cfeh_pkg::D_BATOV];
    live[cfeh_pkg::EV_THERMAL_REGULATION_THRESHOLD] = s_r.det_s[cfeh_pkg::D_THERMAL_REGULATION_THRESHOLD];
    live[cfeh_pkg::EV_OTP] = s_r.det_s[cfeh_pkg::D_OTP];
    live = live & ~cfeh_pkg::NO_LIVE_STAT;

    // Slave: start, stop and bit handling
    if (s_r.scl_s && s_r.sda_p && !s_r.sda_s) begin
      s_nxt.st = cfeh_pkg::CFEH_ADDR;
      s_nxt.bitc = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (s_r.scl_s && !s_r.sda_p && s_r.sda_s) begin
      s_nxt.st = cfeh_pkg::CFEH_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (s_r.st == cfeh_pkg::CFEH_RD) begin
        if (s_r.bitc != 4'h8) begin
          s_nxt.bitc = s_r.bitc + 4'h1;
        end else if (s_r.sda_s) begin
          s_nxt.st = cfeh_pkg::CFEH_IDLE;
        end else begin
          s_nxt.bitc = 4'h0;
          s_nxt.tx = rd(s_r, live);
        end
      end else if (s_r.st == cfeh_pkg::CFEH_ADDR || s_r.st == cfeh_pkg::CFEH_REG || s_r.st == cfeh_pkg::CFEH_WR) begin
        s_nxt.sh = {s_r.sh[6:0], s_r.sda_s};
        s_nxt.bitc = s_r.bitc + 4'h1;
      end
    end else if (scl_fall) begin
      case (s_r.st)
        cfeh_pkg::CFEH_ADDR: begin
          if (s_r.bitc == 4'h8) begin
            if (s_r.sh[7:1] == cfeh_pkg::SLAVE_ADDR) begin
              s_nxt.sda_oe = 1'b1;
              s_nxt.rw = s_r.sh[0];
              s_nxt.st = cfeh_pkg::CFEH_AACK;
            end else begin
              s_nxt.st = cfeh_pkg::CFEH_IDLE;
            end
          end
        end
        cfeh_pkg::CFEH_AACK: begin
          s_nxt.bitc = 4'h0;
          if (s_r.rw) begin
            s_nxt.tx = rd(s_r, live);
            s_nxt.sda_oe = ~s_nxt.tx[7];
            s_nxt.st = cfeh_pkg::CFEH_RD;
          end else begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = cfeh_pkg::CFEH_REG;
          end
        end
        cfeh_pkg::CFEH_REG: begin
          if (s_r.bitc == 4'h8) begin
            s_nxt.ptr = s_r.sh;
            s_nxt.sda_oe = 1'b1;
            s_nxt.st = cfeh_pkg::CFEH_RACK;
          end
        end
        cfeh_pkg::CFEH_RACK, cfeh_pkg::CFEH_WACK: begin
          s_nxt.sda_oe = 1'b0;
          s_nxt.bitc = 4'h0;
          s_nxt.st = cfeh_pkg::CFEH_WR;
        end
        cfeh_pkg::CFEH_WR: begin
          if (s_r.bitc == 4'h8) begin
            if (s_r.ptr[7:2] == cfeh_pkg::REG_MASK0[7:2]) begin
              s_nxt.mask = put(s_r.mask, s_r.ptr[1:0], s_r.sh);
            end else if (s_r.ptr == cfeh_pkg::REG_TOP) begin
              s_nxt.top = s_r.sh & (8'h01 << cfeh_pkg::TOP_TO_DIS_BIT);
            end else if (s_r.ptr == cfeh_pkg::REG_FUNC) begin
              s_nxt.func = s_r.sh & 8'h03;
              s_nxt.hic = 3'h0;
            end else if (s_r.ptr == cfeh_pkg::REG_VBUS) begin
              s_nxt.vbus = s_r.sh & 8'hc0;
            end
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.sda_oe = 1'b1;
            s_nxt.st = cfeh_pkg::CFEH_WACK;
          end
        end
        cfeh_pkg::CFEH_RD: begin
          if (s_r.bitc == 4'h8) begin
            s_nxt.sda_oe = 1'b0;
            if (s_r.ptr >= cfeh_pkg::REG_FLAG0 && s_r.ptr <= cfeh_pkg::REG_FLAG3) begin
              clr = put(27'h0000000, s_r.ptr[1:0], s_r.tx);
            end
            s_nxt.ptr = s_r.ptr + 8'h01;
          end else begin
            s_nxt.sda_oe = ~s_r.tx[3'h7 - s_r.bitc[2:0]];
          end
        end
        default: s_nxt.sda_oe = 1'b0;
      endcase
    end

    // Hang-up timeout
    if (s_r.st != cfeh_pkg::CFEH_IDLE && !s_r.sda_s && !s_r.top[cfeh_pkg::TOP_TO_DIS_BIT]) begin
      if (s_r.to_cnt >= 24'(TIMEOUT_CYC - 1)) begin
        s_nxt.st = cfeh_pkg::CFEH_IDLE;
        s_nxt.sda_oe = 1'b0;
        s_nxt.to_cnt = 24'h000000;
      end else begin
        s_nxt.to_cnt = s_r.to_cnt + 24'h000001;
      end
    end else begin
      s_nxt.to_cnt = 24'h000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault reactions
    ev = ev_i;
    boost = s_r.func[cfeh_pkg::FUNC_BOOST_BIT];
    if (rise[cfeh_pkg::D_VACOV]) begin
      if (boost) begin
        ev[cfeh_pkg::EV_BFAULT] = 1'b1;
        s_nxt.func[cfeh_pkg::FUNC_BOOST_BIT] = 1'b0;
      end else begin
        ev[cfeh_pkg::EV_VACOV] = 1'b1;
      end
    end
    if (!boost) begin
      s_nxt.hic = 3'h0;
    end else if (rise[cfeh_pkg::D_BSHORT]) begin
      if (s_r.hic == cfeh_pkg::HICCUP_LAST) begin
        ev[cfeh_pkg::EV_BFAULT] = 1'b1;
        s_nxt.func[cfeh_pkg::FUNC_BOOST_BIT] = 1'b0;
        s_nxt.hic = 3'h0;
      end else begin
        s_nxt.hic = s_r.hic + 3'h1;
      end
    end
    if (rise[cfeh_pkg::D_OTP]) begin
      ev[cfeh_pkg::EV_OTP] = 1'b1;
      if (boost) begin
        s_nxt.func[cfeh_pkg::FUNC_BOOST_BIT] = 1'b0;
      end
    end
    if (s_r.det_s[cfeh_pkg::D_OTP_OK]) begin
      s_nxt.otp_off = 1'b0;
    end
    if (rise[cfeh_pkg::D_OTP] && !boost) begin
      s_nxt.otp_off = 1'b1;
    end
    ev[cfeh_pkg::EV_SYSOV] = ev[cfeh_pkg::EV_SYSOV] | rise[cfeh_pkg::D_SYSOV];
    ev[cfeh_pkg::EV_BATOV] = ev[cfeh_pkg::EV_BATOV] | rise[cfeh_pkg::D_BATOV];
    ev[cfeh_pkg::EV_THERMAL_REGULATION_THRESHOLD] = ev[cfeh_pkg::EV_THERMAL_REGULATION_THRESHOLD] | rise[cfeh_pkg::D_THERMAL_REGULATION_THRESHOLD];
    ev[cfeh_pkg::EV_SHORT] = ev[cfeh_pkg::EV_SHORT] | rise[cfeh_pkg::D_SHORT];
    if (rise[cfeh_pkg::D_SHIP_EXIT]) begin
      s_nxt.ship = 1'b0;
    end
    if (rise[cfeh_pkg::D_SHORT]) begin
      s_nxt.ship = 1'b1;
    end
    if (rise[cfeh_pkg::D_VBUS_IN]) begin
      s_nxt.depl = 1'b0;
    end
    if (rise[cfeh_pkg::D_DEPL]) begin
      s_nxt.depl = 1'b1;
    end
    s_nxt.sw_stop = (s_r.det_s[cfeh_pkg::D_VACOV] & ~boost) | s_r.det_s[cfeh_pkg::D_SYSOV] | s_r.otp_off;
    s_nxt.sink = s_r.det_s[cfeh_pkg::D_SYSOV];
    s_nxt.path = ~(s_r.ship | s_r.depl);
    s_nxt.chg = s_r.func[cfeh_pkg::FUNC_CHG_BIT] & ~s_r.det_s[cfeh_pkg::D_BATOV];
    s_nxt.thermal_regulation_threshold = s_r.det_s[cfeh_pkg::D_THERMAL_REGULATION_THRESHOLD];
    s_nxt.ovp_sel = (boost && s_r.vbus[cfeh_pkg::VBUS_OVP_LSB + 1]) ? cfeh_pkg::OVP_BOOST_SEL :
      s_r.vbus[cfeh_pkg::VBUS_OVP_LSB +: 2];
    s_nxt.ov_stat = s_r.det_s[cfeh_pkg::D_VACOV] & ~boost;
    s_nxt.code = (s_r.det_s[cfeh_pkg::D_VACOV] && !boost) ? cfeh_pkg::CHG_FAULT : charge_state_i;

    ////////////////////////////////////////////////////////////////////////////
    // Flags and alert pulse
    s_nxt.flags = (s_r.flags & ~clr) | ev;
    if (s_r.int_oe) begin
      if (|(ev & ~s_r.mask)) begin
        s_nxt.pend = 1'b1;
      end
      if (s_r.acnt == 12'h001) begin
        s_nxt.int_oe = 1'b0;
        s_nxt.acnt = cfeh_pkg::ALERT_GAP;
      end else begin
        s_nxt.acnt = s_r.acnt - 12'h001;
      end
    end else if (s_r.acnt != 12'h000) begin
      s_nxt.acnt = s_r.acnt - 12'h001;
      s_nxt.pend = s_r.pend | (|(ev & ~s_r.mask));
    end else if (s_r.pend || (|(ev & ~s_r.mask))) begin
      s_nxt.int_oe = 1'b1;
      s_nxt.acnt = cfeh_pkg::ALERT_CYC;
      s_nxt.pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.scl_m <= 1'b1;
      s_r.scl_s <= 1'b1;
      s_r.scl_p <= 1'b1;
      s_r.sda_m <= 1'b1;
      s_r.sda_s <= 1'b1;
      s_r.sda_p <= 1'b1;
      s_r.st <= cfeh_pkg::CFEH_IDLE;
      s_r.top <= cfeh_pkg::TOP_RST;
      s_r.func <= cfeh_pkg::FUNC_RST;
      s_r.vbus <= cfeh_pkg::VBUS_RST;
      s_r.mask <= cfeh_pkg::MASK_RST;
      s_r.path <= 1'b1;
      s_r.chg <= 1'b1;
      s_r.ovp_sel <= cfeh_pkg::VBUS_RST[cfeh_pkg::VBUS_OVP_LSB +: 2];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.sda_d_o = s_r.od_lvl;
  assign link.sda_d_oe = s_r.sda_oe;
  assign link.int_d_o = s_r.od_lvl;
  assign link.int_d_oe = s_r.int_oe;
  assign switching_stop_o = s_r.sw_stop;
  assign sys_sink_en_o = s_r.sink;
  assign battery_path_switch_o = s_r.path;
  assign charge_enable_o = s_r.chg;
  assign thermal_reg_active_o = s_r.thermal_regulation_threshold;
  assign boost_enable_o = s_r.func[cfeh_pkg::FUNC_BOOST_BIT];
  assign input_overvolt_threshold_sel_o = s_r.ovp_sel;
  assign charge_state_code_o = s_r.code;
  assign input_overvolt_status_o = s_r.ov_stat;
endmodule : cfeh_device

// File: hw/cfeh_host.sv
// Purpose: Host-side bus master for the charger event link
// Assumes: One register per command; link clock made by divider
// Notes: Alert falling edge reported as a one-cycle pulse
module cfeh_host #(
  parameter int SCL_QUARTER = cfeh_pkg::SCL_QUARTER
) (
  input wire logic clk,
  input wire logic reset_n,
  cfeh_link_if.host link,
  input wire logic req_i,
  input wire logic rnw_i,
  input wire logic [7:0] reg_i,
  input wire logic [7:0] wdata_i,
  input wire logic boost_rearm_ok_i,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [7:0] rdata_o,
  output logic alert_o
);
  typedef struct packed {
    logic sda_m;
    logic sda_s;
    logic int_m;
    logic int_s;
    logic int_p;
    cfeh_pkg::cfeh_host_e st;
    logic [1:0] q;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [1:0] step;
    logic [7:0] sh;
    logic rnw;
    logic [7:0] regn;
    logic [7:0] wd;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic od_lvl;
    logic busy;
    logic done;
    logic err;
    logic [7:0] rdata;
    logic alert;
  } cfeh_host_s;

  cfeh_host_s s_r;
  cfeh_host_s s_nxt;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.sda_m = link.sda;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.int_m = link.int_n;
    s_nxt.int_s = s_r.int_m;
    s_nxt.int_p = s_r.int_s;
    s_nxt.alert = s_r.int_p & ~s_r.int_s;
    s_nxt.done = 1'b0;
    s_nxt.err = 1'b0;
    tick = (s_r.div == 8'h00);
    s_nxt.div = tick ? 8'(SCL_QUARTER - 1) : s_r.div - 8'h01;
    if (s_r.st != cfeh_pkg::CFEH_H_IDLE && tick) begin
      s_nxt.q = s_r.q + 2'h1;
    end
    case (s_r.st)
      cfeh_pkg::CFEH_H_IDLE: begin
        s_nxt.q = 2'h0;
        if (req_i) begin
          if (!rnw_i && reg_i == cfeh_pkg::REG_FUNC && wdata_i[cfeh_pkg::FUNC_BOOST_BIT] && !boost_rearm_ok_i) begin
            s_nxt.err = 1'b1;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st = cfeh_pkg::CFEH_H_START;
            s_nxt.busy = 1'b1;
            s_nxt.rnw = rnw_i;
            s_nxt.regn = reg_i;
            s_nxt.wd = wdata_i;
            s_nxt.sh = {cfeh_pkg::SLAVE_ADDR, 1'b0};
            s_nxt.step = 2'h0;
            s_nxt.bitn = 4'h0;
            s_nxt.nack = 1'b0;
          end
        end
      end
      cfeh_pkg::CFEH_H_START: begin
        if (tick && s_r.q == 2'h0) begin
          s_nxt.sda_oe = 1'b1;
        end else if (tick && s_r.q == 2'h1) begin
          s_nxt.scl_oe = 1'b1;
          s_nxt.st = cfeh_pkg::CFEH_H_BIT;
          s_nxt.q = 2'h0;
        end
      end
      cfeh_pkg::CFEH_H_BIT: begin
        if (tick) begin
          case (s_r.q)
            2'h0: s_nxt.sda_oe = (s_r.bitn != 4'h8) && !(s_r.step == 2'h3) && !s_r.sh[7];
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (s_r.bitn != 4'h8) begin
                s_nxt.sh = {s_r.sh[6:0], s_r.sda_s};
              end else begin
                s_nxt.nack = s_r.sda_s && (s_r.step != 2'h3);
              end
            end
            default: begin
              s_nxt.scl_oe = 1'b1;
              s_nxt.bitn = s_r.bitn + 4'h1;
              if (s_r.bitn == 4'h8) begin
                s_nxt.bitn = 4'h0;
                s_nxt.step = s_r.step + 2'h1;
                if (s_r.nack) begin
                  s_nxt.err = 1'b1;
                  s_nxt.st = cfeh_pkg::CFEH_H_STOP;
                end else if (s_r.step == 2'h0) begin
                  s_nxt.sh = s_r.regn;
                end else if (s_r.step == 2'h1 && !s_r.rnw) begin
                  s_nxt.sh = s_r.wd;
                end else if (s_r.step == 2'h1) begin
                  s_nxt.sh = {cfeh_pkg::SLAVE_ADDR, 1'b1};
                  s_nxt.st = cfeh_pkg::CFEH_H_RSTART;
                end else if (s_r.step == 2'h2 && s_r.rnw) begin
                  s_nxt.sh = 8'hff;
                end else begin
                  s_nxt.rdata = s_r.rnw ? s_r.sh : s_r.rdata;
                  s_nxt.st = cfeh_pkg::CFEH_H_STOP;
                end
              end
            end
          endcase
        end
      end
      cfeh_pkg::CFEH_H_RSTART: begin
        if (tick) begin
          case (s_r.q)
            2'h0: s_nxt.sda_oe = 1'b0;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b1;
            default: begin
              s_nxt.scl_oe = 1'b1;
              s_nxt.st = cfeh_pkg::CFEH_H_BIT;
            end
          endcase
        end
      end
      cfeh_pkg::CFEH_H_STOP: begin
        if (tick) begin
          case (s_r.q)
            2'h0: s_nxt.sda_oe = 1'b1;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b0;
            default: begin
              s_nxt.st = cfeh_pkg::CFEH_H_IDLE;
              s_nxt.busy = 1'b0;
              s_nxt.done = 1'b1;
            end
          endcase
        end
      end
      default: s_nxt.st = cfeh_pkg::CFEH_H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.sda_m <= 1'b1;
      s_r.sda_s <= 1'b1;
      s_r.int_m <= 1'b1;
      s_r.int_s <= 1'b1;
      s_r.int_p <= 1'b1;
      s_r.st <= cfeh_pkg::CFEH_H_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.scl_h_o = s_r.od_lvl;
  assign link.scl_h_oe = s_r.scl_oe;
  assign link.sda_h_o = s_r.od_lvl;
  assign link.sda_h_oe = s_r.sda_oe;
  assign busy_o = s_r.busy;
  assign done_o = s_r.done;
  assign err_o = s_r.err;
  assign rdata_o = s_r.rdata;
  assign alert_o = s_r.alert;
endmodule : cfeh_host

// File: verification/cfeh_link_assertions.sv
// Purpose: Wire checks on the charger event link
// Assumes: Plain signals of cfeh_link_if
// Notes: Alert length counted in helper logic
module cfeh_link_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_h_o,
  input wire logic scl_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic int_d_o,
  input wire logic int_d_oe,
  input wire logic scl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cnt_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cnt_r <= 12'h000;
    else cnt_r <= int_d_oe ? cnt_r + 12'h001 : 12'h000;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_alert_od; int_d_oe |-> !int_d_o; endproperty
  a_alert_od: assert property (p_alert_od) else $error("alert driven high");
  property p_sda_od; sda_d_oe |-> !sda_d_o; endproperty
  a_sda_od: assert property (p_sda_od) else $error("data driven high");
  property p_pulse_len; $fell(int_d_oe) |-> cnt_r == 12'ha00; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("alert length wrong");
  property p_pulse_max; cnt_r <= 12'ha00; endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("alert too long");
  property p_gap; $fell(int_d_oe) |-> !int_d_oe [*4]; endproperty
  a_gap: assert property (p_gap) else $error("alert gap short");
  property p_dev_sda_scl_low; $changed(sda_d_oe) |-> !scl; endproperty
  a_dev_sda_scl_low: assert property (p_dev_sda_scl_low) else $error("data moved with clock high");
  property p_ack_hold; $rose(sda_d_oe) |-> sda_d_oe [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data bit not held");
  property p_scl_od; scl_h_oe |-> !scl_h_o; endproperty
  a_scl_od: assert property (p_scl_od) else $error("clock driven high");
  c_pulse: cover property ($fell(int_d_oe));
  c_ack: cover property ($rose(sda_d_oe));
  c_clock: cover property ($rose(scl_h_oe));
endmodule : cfeh_link_assertions

// File: verification/charger_fault_event_host_link_bench.sv
// Purpose: Bench for both ends of the charger event link
// Assumes: Short bus timeout in simulation
// Notes: Host end masters the bus
module charger_fault_event_host_link_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, req_i = 0, rnw_i = 0;
  logic [7:0] reg_i = '0, wdata_i = '0, rdata_o;
  logic [10:0] det_i = '0;
  logic [26:0] ev_i = '0, stat_i = '0;
  logic [3:0] charge_state_i = '0, charge_state_code_o;
  logic done_o, alert_o, switching_stop_o, sys_sink_en_o, charge_enable_o, input_overvolt_status_o;
  logic battery_path_switch_o, thermal_reg_active_o, boost_enable_o, busy_o, err_o, ok_i = 1'b1;
  logic [1:0] input_overvolt_threshold_sel_o;
  int seed = 61768, n_mismatch = 0, tests_run = 0, cyc = 0;
  cfeh_link_if link();
  cfeh_device #(.TIMEOUT_CYC(2000)) cfeh_device_inst (.clk, .reset_n, .link(link), .det_i, .ev_i, .stat_i,
    .charge_state_i, .switching_stop_o, .sys_sink_en_o, .battery_path_switch_o, .charge_enable_o,
    .thermal_reg_active_o, .boost_enable_o, .input_overvolt_threshold_sel_o, .charge_state_code_o,
    .input_overvolt_status_o);
  cfeh_host cfeh_host_inst (.clk, .reset_n, .link(link), .req_i, .rnw_i, .reg_i, .wdata_i,
    .boost_rearm_ok_i(ok_i), .busy_o, .done_o, .err_o, .rdata_o, .alert_o);
  cfeh_link_assertions cfeh_link_assertions_inst (.clk, .reset_n, .scl_h_o(link.scl_h_o),
    .scl_h_oe(link.scl_h_oe), .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe), .int_d_o(link.int_d_o),
    .int_d_oe(link.int_d_oe), .scl(link.scl));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task xfer(input logic r, input logic [7:0] a, input logic [7:0] w);
    int k;
    @(posedge clk);
    req_i <= 1'b1;
    rnw_i <= r;
    reg_i <= a;
    wdata_i <= w;
    @(posedge clk);
    req_i <= 1'b0;
    for (k = 0; k < 9000 && done_o !== 1'b1; k++) @(negedge clk);
    chk({5'h00, busy_o, done_o, err_o}, {7'h01, ~ok_i});
    @(negedge clk);
  endtask : xfer
  task rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    chk(rdata_o, e);
  endtask : rdc
  task ev(input logic [2:0] b, output logic s);
    int k;
    s = 1'b0;
    @(posedge clk);
    ev_i <= 27'h0000001 << b;
    @(posedge clk);
    ev_i <= '0;
    for (k = 0; k < 3000 && !s; k++) begin
      @(negedge clk);
      s = (alert_o === 1'b1);
    end
  endtask : ev
  task conclude;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      conclude;
    end
  end
  initial begin
    logic s;
    logic [2:0] b, c;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    stat_i <= 27'($random(seed));
    charge_state_i <= 4'($random(seed));
    repeat (4) @(posedge clk);
    rdc(8'h01, 8'h00);
    rdc(8'h30, 8'hff);
    rdc(8'h33, 8'h07);
    rdc(8'h10, stat_i[7:0] & ~cfeh_pkg::NO_LIVE_STAT[7:0]);
    $display("Reset test done");
    ev(3'h3, s);
    chk({7'h00, s}, 8'h00);
    rdc(8'h20, 8'h08);
    rdc(8'h20, 8'h00);
    xfer(1'b0, 8'h30, 8'h00);
    b = 3'($random(seed));
    c = 3'($random(seed));
    ev(b, s);
    chk({7'h00, s}, 8'h01);
    ev(c, s);
    chk({7'h00, s}, 8'h01);
    rdc(8'h20, (8'h01 << b) | (8'h01 << c));
    $display("Alert test done");
    xfer(1'b0, 8'h01, 8'h08);
    rdc(8'h01, 8'h08);
    @(posedge clk) ok_i <= 1'b0;
    xfer(1'b0, 8'h02, 8'h03);
    @(posedge clk) ok_i <= 1'b1;
    rdc(8'h02, 8'h01);
    chk({4'h0, charge_state_code_o}, {4'h0, charge_state_i});
    @(posedge clk) det_i <= 11'h02f;
    repeat (10) @(negedge clk);
    chk({4'h0, charge_state_code_o}, {4'h0, cfeh_pkg::CHG_FAULT});
    chk({7'h00, input_overvolt_status_o}, 8'h01);
    chk({6'h00, switching_stop_o, sys_sink_en_o}, 8'h03);
    chk({7'h00, charge_enable_o}, 8'h00);
    chk({6'h00, battery_path_switch_o, thermal_reg_active_o}, 8'h01);
    chk({5'h00, boost_enable_o, input_overvolt_threshold_sel_o}, 8'h01);
    rdc(8'h21, 8'h64);
    rdc(8'h22, 8'h50);
    $display("Fault test done");
    conclude;
  end
endmodule : charger_fault_event_host_link_bench
